// *** dv/aesd_encrypt_dma_chk.sv ***
// ==========================================================
// port level checks
module aesd_encrypt_dma_chk (
   input wire logic                       clk_sys,
   input wire logic                       srst,
   input wire logic [11:0]                avs_address,
   input wire logic                       avs_read,
   input wire logic                       avs_write,
   input wire logic [31:0]                avs_writedata,
   input wire logic [3:0]                 avs_byteenable,
   input wire logic                       avs_waitrequest,
   input wire aesd_pkg::aesd_mem_req_type memReq,
   input wire aesd_pkg::aesd_mem_rsp_type memRsp,
   input wire logic                       coreBusy,
   input wire logic                       corePreempt,
   input wire logic                       coreClaim
);
   timeunit 1ns;
   timeprecision 1ns;
   import aesd_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic        reqD_r;
   logic [31:0] base_r;
   // fetch start address, stores are judged relative to it
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         reqD_r <= 1'b0;
         base_r <= 32'h0;
      end else begin
         reqD_r <= memReq.req;
         if (memReq.req && !reqD_r && !memReq.we)
            base_r <= memReq.addr;
      end
   end
   sequence startTaken;
      avs_write && !avs_waitrequest && avs_address == OFS_START
      && avs_writedata[0] && avs_byteenable[0];
   endsequence
   sequence stopTaken;
      avs_write && !avs_waitrequest && avs_address == OFS_STOP
      && avs_writedata[0] && avs_byteenable[0];
   endsequence
   AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("bus answer not after one wait state");
   AST_DMA_RAM: assert property (memReq.req |-> {1'b0, memReq.addr} >= RAM_BASE
      && {1'b0, memReq.addr} < RAM_BASE + RAM_SIZE) else $error("dma outside ram");
   AST_REQ_HOLD: assert property (memReq.req && !memRsp.ack |=> memReq.req
      && $stable(memReq.addr) && $stable(memReq.we) && $stable(memReq.wdata))
      else $error("dma request changed before ack");
   AST_BUSY_START: assert property (startTaken ##0 (coreBusy && !coreClaim)
      |=> !coreClaim [*2]) else $error("start ran while core busy");
   AST_FETCH_CAUSE: assert property ($rose(memReq.req) && !memReq.we
      |-> $past(avs_address) == OFS_START) else $error("fetch without start");
   AST_FETCH_MAP: assert property (memReq.req && !memReq.we && reqD_r
      |-> memReq.addr - base_r < 32'h20) else $error("fetch outside key and clear");
   AST_STORE_MAP: assert property (memReq.req && memReq.we
      |-> memReq.addr - base_r inside {32'h20, 32'h24, 32'h28, 32'h2c})
      else $error("store outside cipher area");
   AST_STOP: assert property (stopTaken ##0 coreClaim |-> ##[1:24] !coreClaim)
      else $error("stop did not abort");
   AST_PREEMPT: assert property (corePreempt && coreClaim |-> ##[1:24] !coreClaim)
      else $error("conflict did not abort");
   AST_IDLE_NO_DMA: assert property ($fell(coreClaim) |-> !memReq.req)
      else $error("dma open at end of run");
   AST_CLAIM: assert property (memReq.req |-> coreClaim)
      else $error("dma without core claim");
endmodule : aesd_encrypt_dma_chk

// *** dv/aesd_ram_model.sv ***
// ==========================================================
// data ram seen by the dma master, answer delay set by the bench
module aesd_ram_model (
   input  wire logic                       clk_sys,
   input  wire logic                       srst,
   input  wire aesd_pkg::aesd_mem_req_type memReq,
   input  wire logic [2:0]                 stallCycles,
   output aesd_pkg::aesd_mem_rsp_type      memRsp
);
   timeunit 1ns;
   timeprecision 1ns;
   import aesd_pkg::*;
   logic [31:0] mem [0:255];
   logic [2:0]  waitCnt_r;
   // plain always: the bench also loads mem directly
   always @(posedge clk_sys) begin
      if (srst) begin
         memRsp <= '0;
         waitCnt_r <= 3'h0;
      end else if (memReq.req && !memRsp.ack && waitCnt_r >= stallCycles) begin
         memRsp.ack <= 1'b1;
         memRsp.rdata <= memReq.we ? ~memRsp.rdata : mem[memReq.addr[9:2]];
         if (memReq.we)
            mem[memReq.addr[9:2]] <= memReq.wdata;
         waitCnt_r <= 3'h0;
      end else begin
         memRsp.ack <= 1'b0;
         memRsp.rdata <= ~memRsp.rdata; // idle data toggles, never stale
         waitCnt_r <= memReq.req ? waitCnt_r + 3'h1 : 3'h0;
      end
   end
endmodule : aesd_ram_model

// *** dv/testbench.sv ***
// ==========================================================
// bench top
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import aesd_pkg::*;
   localparam logic [127:0] KEY = 128'h000102030405060708090a0b0c0d0e0f;
   localparam logic [127:0] CLR = 128'h00112233445566778899aabbccddeeff;
   localparam logic [127:0] CIP = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
   logic             clk_sys = 1'b0;
   logic             srst = 1'b1;
   logic [11:0]      avsAddress = 12'h0;
   logic             avsRead = 1'b0, avsWrite = 1'b0;
   logic [31:0]      avsWritedata = 32'h0, avsReaddata, rdData, ptr;
   logic [3:0]       avsByteen = 4'hf;
   logic             avsWaitrequest, coreClaim, irq;
   logic             coreBusy = 1'b0, corePreempt = 1'b0;
   logic [2:0]       stallCycles = 3'h0;
   aesd_mem_req_type memReq;
   aesd_mem_rsp_type memRsp;
   int               failures = 0, checksDone = 0, seed = 32'h2ad6;
   // 10 MHz
   always #50 clk_sys = ~clk_sys;
   aesd_encrypt_dma dut_u (.clk_sys, .srst, .avs_address(avsAddress),
      .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
      .avs_byteenable(avsByteen), .avs_readdata(avsReaddata),
      .avs_waitrequest(avsWaitrequest), .memReq, .memRsp, .coreBusy, .corePreempt,
      .coreClaim, .irq);
   aesd_ram_model ram_u (.clk_sys, .srst, .memReq, .stallCycles, .memRsp);
   task automatic complete_run;
      $display("TB: %0d checks, %0d failures", checksDone, failures);
      if (failures == 0 && checksDone > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // little endian word i of a 16 byte string
   function automatic logic [31:0] word_of(input logic [127:0] v, input int i);
      logic [31:0] w;
      w = v[127-32*i -: 32];
      return {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction : word_of
   // one bus access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      avsRead <= ~wr;
      avsWrite <= wr;
      avsAddress <= a;
      avsWritedata <= d;
      // waitrequest and read data are both taken at the answering rising edge
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (avsWaitrequest === 1'b0)
            break;
      end
      rdData = avsReaddata;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      if (n == 20) begin
         failures++;
         complete_run();
      end
   endtask : bus
   task automatic chk_irq(input logic exp);
      @(negedge clk_sys);
      check({31'h0, irq}, {31'h0, exp});
   endtask : chk_irq
   task automatic wait_idle;
      int n;
      @(posedge clk_sys);
      for (n = 0; n < 400; n++) begin
         @(negedge clk_sys);
         if (coreClaim === 1'b0)
            break;
      end
      if (n == 400) begin
         failures++;
         complete_run();
      end
   endtask : wait_idle
   // random word aligned structure inside ram, preloaded
   task automatic load_struct;
      ptr = RAM_BASE[31:0] + ($random(seed) & 32'hfc);
      for (int i = 0; i < 12; i++)
         ram_u.mem[ptr[9:2] + i] = i < 4 ? word_of(KEY, i) : i < 8 ?
            word_of(CLR, i - 4) : ~word_of(CIP, i - 8);
      bus(1'b1, OFS_PTR, ptr);
      bus(1'b0, OFS_PTR, 32'h0);
      check(rdData, ptr);
   endtask : load_struct
   task automatic run_block(input int k);
      stallCycles <= (k == 0) ? 3'h0 : 3'($random(seed));
      load_struct();
      bus(1'b1, OFS_START, 32'h1);
      wait_idle();
      for (int i = 0; i < 4; i++)
         check(ram_u.mem[ptr[9:2] + 8 + i], word_of(CIP, i));
      bus(1'b0, OFS_DONE, 32'h0);
      check(rdData, 32'h1);
      bus(1'b0, OFS_ERROR, 32'h0);
      check(rdData, 32'h0);
      chk_irq(1'b1);
      bus(1'b1, OFS_DONE, 32'h0);
      chk_irq(1'b0);
      $display("TB: block run %0d done", k);
   endtask : run_block
   // abort by stop or by a higher priority unit during fetch
   task automatic run_abort(input logic byPreempt);
      stallCycles <= 3'h4;
      load_struct();
      bus(1'b1, OFS_START, 32'h1);
      repeat (3) @(negedge clk_sys);
      check({31'h0, coreClaim}, 32'h1);
      if (byPreempt) begin
         @(posedge clk_sys);
         corePreempt <= 1'b1;
         @(posedge clk_sys);
         corePreempt <= 1'b0;
      end else
         bus(1'b1, OFS_STOP, 32'h1);
      wait_idle();
      bus(1'b0, OFS_ERROR, 32'h0);
      check(rdData, 32'h1);
      bus(1'b0, OFS_DONE, 32'h0);
      check(rdData, 32'h0);
      chk_irq(1'b1);
      bus(1'b1, OFS_ERROR, 32'h0);
      chk_irq(1'b0);
      $display("TB: abort %0d done", byPreempt);
   endtask : run_abort
   // ==========================================================
   // main sequence
   initial begin
      static logic [11:0] regs [6] = '{OFS_DONE, OFS_ERROR, OFS_IRQSET, OFS_IRQCLR, OFS_PTR,
                                       12'h200};
      repeat (10) @(posedge clk_sys);
      srst <= 1'b0;
      bus(1'b1, 12'h200, 32'($random(seed)));
      foreach (regs[i]) begin
         bus(1'b0, regs[i], 32'h1);
         check(rdData, 32'h0);
      end
      $display("TB: reset values done");
      bus(1'b1, OFS_IRQSET, 32'h3);
      bus(1'b1, OFS_IRQCLR, 32'h1);
      bus(1'b0, OFS_IRQCLR, 32'h0);
      check(rdData, 32'h2);
      bus(1'b1, OFS_DONE, 32'h1);
      chk_irq(1'b0);
      bus(1'b1, OFS_IRQSET, 32'h1);
      bus(1'b0, OFS_IRQSET, 32'h0);
      check(rdData, 32'h3);
      chk_irq(1'b1);
      bus(1'b1, OFS_DONE, 32'h0);
      chk_irq(1'b0);
      avsByteen <= 4'he;
      bus(1'b1, OFS_START, 32'h1);
      avsByteen <= 4'hf;
      repeat (3) @(negedge clk_sys);
      check({31'h0, coreClaim}, 32'h0);
      $display("TB: irq and lanes done");
      for (int k = 0; k < 4; k++)
         run_block(k);
      run_abort(1'b0);
      run_abort(1'b1);
      @(posedge clk_sys);
      coreBusy <= 1'b1;
      bus(1'b1, OFS_START, 32'h1);
      repeat (3) @(negedge clk_sys);
      check({31'h0, coreClaim}, 32'h0);
      @(posedge clk_sys);
      coreBusy <= 1'b0;
      bus(1'b0, OFS_ERROR, 32'h0);
      check(rdData, 32'h1);
      // status read returns the pending error and clears it
      bus(1'b0, OFS_IRQSTAT, 32'h0);
      check(rdData, 32'h2);
      bus(1'b0, OFS_ERROR, 32'h0);
      check(rdData, 32'h0);
      // structure running past the end of ram is refused with an error
      bus(1'b1, OFS_PTR, RAM_BASE[31:0] + RAM_SIZE[31:0] - 32'h20);
      bus(1'b1, OFS_START, 32'h1);
      repeat (3) @(negedge clk_sys);
      check({31'h0, coreClaim}, 32'h0);
      bus(1'b0, OFS_ERROR, 32'h0);
      check(rdData, 32'h1);
      $display("TB: busy start done");
      complete_run();
   end
endmodule : testbench
bind aesd_encrypt_dma aesd_encrypt_dma_chk chk_u (.clk_sys, .srst, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .memReq, .memRsp,
   .coreBusy, .corePreempt, .coreClaim);

// *** rtl/aesd_encrypt_dma.sv ***
module aesd_encrypt_dma (
   input  wire logic                      clk_sys,
   input  wire logic                      srst,
   input  wire logic [11:0]               avs_address,
   input  wire logic                      avs_read,
   input  wire logic                      avs_write,
   input  wire logic [31:0]               avs_writedata,
   input  wire logic [3:0]                avs_byteenable,
   output logic      [31:0]               avs_readdata,
   output logic                           avs_waitrequest,
   output aesd_pkg::aesd_mem_req_type     memReq,
   input  wire aesd_pkg::aesd_mem_rsp_type memRsp,
   input  wire logic                      coreBusy,
   input  wire logic                      corePreempt,
   output logic                           coreClaim,
   output logic                           irq
);
   import aesd_pkg::*;

   // ==========================================================
   // aes arithmetic helpers
   function automatic logic [7:0] xtime(input logic [7:0] a);
      xtime = {a[6:0], 1'b0} ^ (a[7] ? GF_POLY : 8'h00);
   endfunction : xtime

   function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] r;
      p = a;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) begin
            r = r ^ p;
         end
         p = xtime(p);
      end
      gmul = r;
   endfunction : gmul

   // inverse as x^254, then the affine map; trades area for no table
   function automatic logic [7:0] sbox(input logic [7:0] x);
      logic [7:0] p;
      logic [7:0] r;
      logic [7:0] e;
      p = x;
      r = 8'h01;
      e = 8'hfe;
      for (int i = 0; i < 8; i++) begin
         if (e[i]) begin
            r = gmul(r, p);
         end
         p = gmul(p, p);
      end
      sbox = r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]}
           ^ {r[3:0], r[7:4]} ^ AFFINE_C;
   endfunction : sbox

   function automatic logic [31:0] subWord(input logic [31:0] w);
      subWord = {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
   endfunction : subWord

   // next round key from the current one
   function automatic logic [127:0] nextKey(input logic [127:0] k, input logic [7:0] rc);
      logic [31:0] t;
      logic [31:0] w0;
      logic [31:0] w1;
      logic [31:0] w2;
      logic [31:0] w3;
      t  = subWord({k[23:0], k[31:24]}) ^ {rc, 24'h000000};
      w0 = k[127:96] ^ t;
      w1 = k[95:64] ^ w0;
      w2 = k[63:32] ^ w1;
      w3 = k[31:0] ^ w2;
      nextKey = {w0, w1, w2, w3};
   endfunction : nextKey

   // one cipher round; byte i of the block sits at [127-8i -: 8]
   function automatic logic [127:0] aesRound(input logic [127:0] s, input logic [127:0] rk,
                                             input logic last);
      logic [7:0]   b [16];
      logic [7:0]   a0;
      logic [7:0]   a1;
      logic [7:0]   a2;
      logic [7:0]   a3;
      logic [127:0] o;
      o = 128'h0;
      for (int i = 0; i < 16; i++) begin
         b[i] = sbox(s[127 - 8*(((i % 4) + 4*(((i / 4) + (i % 4)) % 4))) -: 8]);
      end
      for (int c = 0; c < 4; c++) begin
         a0 = b[4*c];
         a1 = b[4*c+1];
         a2 = b[4*c+2];
         a3 = b[4*c+3];
         if (last) begin
            o[127 - 32*c -: 32] = {a0, a1, a2, a3};
         end else begin
            o[127 - 32*c -: 32] = {xtime(a0) ^ gmul(a1, 8'h03) ^ a2 ^ a3,
                                   a0 ^ xtime(a1) ^ gmul(a2, 8'h03) ^ a3,
                                   a0 ^ a1 ^ xtime(a2) ^ gmul(a3, 8'h03),
                                   gmul(a0, 8'h03) ^ a1 ^ a2 ^ xtime(a3)};
         end
      end
      aesRound = o ^ rk;
   endfunction : aesRound

   // memory words are little endian: byte 0 of a word in bits 7:0
   function automatic logic [31:0] getWord(input logic [127:0] blk, input logic [1:0] i);
      logic [31:0] w;
      w = 32'h0;
      for (int k = 0; k < 4; k++) begin
         w[8*k +: 8] = blk[127 - 8*(4*i + k) -: 8];
      end
      getWord = w;
   endfunction : getWord

   function automatic logic [127:0] putWord(input logic [127:0] blk, input logic [1:0] i,
                                            input logic [31:0] w);
      logic [127:0] o;
      o = blk;
      for (int k = 0; k < 4; k++) begin
         o[127 - 8*(4*i + k) -: 8] = w[8*k +: 8];
      end
      putWord = o;
   endfunction : putWord

   // ==========================================================
   // bus slave: one wait state, then the answer
   logic        respDone_r;
   logic [31:0] readData_r;
   logic        access;
   logic        wrFire;
   logic        rdFire;
   logic        lane0;

   assign access          = avs_read | avs_write;
   assign avs_waitrequest = access & ~respDone_r;
   assign wrFire          = avs_write & respDone_r;
   assign rdFire          = avs_read & respDone_r;
   assign lane0           = avs_byteenable[0];
   assign avs_readdata    = readData_r;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         respDone_r <= 1'b0;
      end else begin
         respDone_r <= access & ~respDone_r;
      end
   end

   // ==========================================================
   // software state
   aesd_state_type state_r;
   logic [31:0]    ptr_r;
   logic           doneEv_r;
   logic           errEv_r;
   logic [1:0]     irqEn_r;
   logic           doneSet;
   logic           errSet;
   logic           startFire;
   logic           stopFire;
   logic           busy;

   assign busy      = (state_r != ST_IDLE);
   assign startFire = wrFire & (avs_address == OFS_START) & lane0 & avs_writedata[BIT_TRIG];
   assign stopFire  = wrFire & (avs_address == OFS_STOP) & lane0 & avs_writedata[BIT_TRIG];

   // read data captured in the wait cycle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         readData_r <= 32'h0;
      end else begin
         unique case (avs_address)
            OFS_DONE:    readData_r <= {31'h0, doneEv_r};
            OFS_ERROR:   readData_r <= {31'h0, errEv_r};
            OFS_IRQSET:  readData_r <= {30'h0, irqEn_r};
            OFS_IRQCLR:  readData_r <= {30'h0, irqEn_r};
            OFS_IRQSTAT: readData_r <= {30'h0, errEv_r, doneEv_r};
            OFS_PTR:     readData_r <= ptr_r;
            default:     readData_r <= 32'h0;
         endcase
      end
   end

   // pointer with byte lanes
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ptr_r <= PTR_RESET;
      end else if (wrFire && avs_address == OFS_PTR) begin
         for (int k = 0; k < 4; k++) begin
            if (avs_byteenable[k]) begin
               ptr_r[8*k +: 8] <= avs_writedata[8*k +: 8];
            end
         end
      end
   end

   // interrupt enables, set and clear by writing ones
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irqEn_r <= IRQEN_RESET;
      end else if (wrFire && lane0 && avs_address == OFS_IRQSET) begin
         irqEn_r <= irqEn_r | avs_writedata[1:0];
      end else if (wrFire && lane0 && avs_address == OFS_IRQCLR) begin
         irqEn_r <= irqEn_r & ~avs_writedata[1:0];
      end
   end

   // events: hardware set wins; a status read clears only the bits it returned
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         doneEv_r <= 1'b0;
         errEv_r  <= 1'b0;
      end else begin
         if (doneSet) begin
            doneEv_r <= 1'b1;
         end else if (wrFire && lane0 && avs_address == OFS_DONE) begin
            doneEv_r <= avs_writedata[BIT_DONE];
         end else if (rdFire && avs_address == OFS_IRQSTAT && readData_r[BIT_DONE]) begin
            doneEv_r <= 1'b0;
         end
         if (errSet) begin
            errEv_r <= 1'b1;
         end else if (wrFire && lane0 && avs_address == OFS_ERROR) begin
            errEv_r <= avs_writedata[BIT_DONE];
         end else if (rdFire && avs_address == OFS_IRQSTAT && readData_r[BIT_ERR]) begin
            errEv_r <= 1'b0;
         end
      end
   end

   assign irq = (doneEv_r & irqEn_r[BIT_DONE]) | (errEv_r & irqEn_r[BIT_ERR]);

   // ==========================================================
   // dma and cipher sequencer
   aesd_mem_req_type memReq_r;
   logic [3:0]       wordIdx_r;
   logic [3:0]       round_r;
   logic [7:0]       rcon_r;
   logic [127:0]     keyBuf_r;
   logic [127:0]     dataBuf_r;
   logic             abortPend_r;
   logic             ptrInRam;
   logic             quitNow;
   logic [127:0]     rkNext;
   logic [127:0]     roundOut;

   // whole structure must lie inside the ram window
   assign ptrInRam = ({1'b0, ptr_r} >= RAM_BASE)
                   && ({1'b0, ptr_r} + STRUCT_LEN <= RAM_BASE + RAM_SIZE);
   // an access in flight must complete before any abort takes hold
   assign quitNow  = abortPend_r & busy & (~memReq_r.req | memRsp.ack);
   assign rkNext   = nextKey(keyBuf_r, rcon_r);
   assign roundOut = aesRound(dataBuf_r, rkNext, round_r == LAST_ROUND);
   assign memReq   = memReq_r;
   assign coreClaim = busy;

   // a stop or a higher-priority claim marks the run for abort
   always_ff @(posedge clk_sys) begin
      if (srst || !busy) begin
         abortPend_r <= 1'b0;
      end else if (stopFire || corePreempt) begin
         abortPend_r <= 1'b1;
      end
   end

   // event pulses
   assign errSet  = quitNow
                  | (startFire & (busy | coreBusy | ~ptrInRam));
   assign doneSet = (state_r == ST_STORE) & ~abortPend_r & memRsp.ack
                  & (wordIdx_r == LAST_STORE);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_r   <= ST_IDLE;
         memReq_r  <= '0;
         wordIdx_r <= 4'h0;
         round_r   <= 4'h0;
         rcon_r    <= RCON_FIRST;
      end else if (quitNow) begin
         state_r  <= ST_IDLE;
         memReq_r <= '0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (startFire && !coreBusy && ptrInRam) begin
                  state_r        <= ST_FETCH;
                  wordIdx_r      <= 4'h0;
                  memReq_r.req   <= 1'b1;
                  memReq_r.we    <= 1'b0;
                  memReq_r.addr  <= ptr_r + KEY_OFS;
                  memReq_r.wdata <= 32'h0;
               end
            end
            ST_FETCH: begin
               if (memRsp.ack) begin
                  if (wordIdx_r == LAST_FETCH) begin
                     memReq_r.req <= 1'b0;
                     state_r      <= ST_CRYPT;
                     round_r      <= 4'h0;
                     rcon_r       <= RCON_FIRST;
                  end else begin
                     memReq_r.addr <= memReq_r.addr + 32'h4;
                  end
                  wordIdx_r <= wordIdx_r + 4'h1;
               end
            end
            ST_CRYPT: begin
               if (round_r == LAST_ROUND) begin
                  state_r        <= ST_STORE;
                  memReq_r.req   <= 1'b1;
                  memReq_r.we    <= 1'b1;
                  memReq_r.addr  <= ptr_r + CIPHER_OFS;
                  memReq_r.wdata <= getWord(roundOut, 2'h0);
                  wordIdx_r      <= FIRST_STORE;
               end else begin
                  round_r <= round_r + 4'h1;
                  if (round_r != 4'h0) begin
                     rcon_r <= xtime(rcon_r);
                  end
               end
            end
            ST_STORE: begin
               if (memRsp.ack) begin
                  if (wordIdx_r == LAST_STORE) begin
                     memReq_r <= '0;
                     state_r  <= ST_IDLE;
                  end else begin
                     memReq_r.addr  <= memReq_r.addr + 32'h4;
                     memReq_r.wdata <= getWord(dataBuf_r, wordIdx_r[1:0] + 2'h1);
                  end
                  wordIdx_r <= wordIdx_r + 4'h1;
               end
            end
            default: begin
               state_r  <= ST_IDLE;
               memReq_r <= '0;
            end
         endcase
      end
   end

   // key and block datapath: fetch, initial key add, ten rounds
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         keyBuf_r  <= 128'h0;
         dataBuf_r <= 128'h0;
      end else if (state_r == ST_FETCH && memRsp.ack) begin
         if (wordIdx_r < 4'h4) begin
            keyBuf_r <= putWord(keyBuf_r, wordIdx_r[1:0], memRsp.rdata);
         end else begin
            dataBuf_r <= putWord(dataBuf_r, wordIdx_r[1:0], memRsp.rdata);
         end
      end else if (state_r == ST_CRYPT && round_r == 4'h0) begin
         dataBuf_r <= dataBuf_r ^ keyBuf_r;
      end else if (state_r == ST_CRYPT) begin
         keyBuf_r  <= rkNext;
         dataBuf_r <= roundOut;
      end
   end

endmodule : aesd_encrypt_dma

// *** rtl/aesd_pkg.sv ***
package aesd_pkg;

   // ==========================================================
   // register map (byte addresses)
   localparam logic [11:0] OFS_START   = 12'h000;
   localparam logic [11:0] OFS_STOP    = 12'h004;
   localparam logic [11:0] OFS_DONE    = 12'h100;
   localparam logic [11:0] OFS_ERROR   = 12'h104;
   localparam logic [11:0] OFS_IRQSET  = 12'h304;
   localparam logic [11:0] OFS_IRQCLR  = 12'h308;
   localparam logic [11:0] OFS_IRQSTAT = 12'h400;
   localparam logic [11:0] OFS_PTR     = 12'h504;

   // ==========================================================
   // field positions and reset values
   localparam int          BIT_TRIG    = 0;
   localparam int          BIT_DONE    = 0;
   localparam int          BIT_ERR     = 1;
   localparam logic [31:0] PTR_RESET   = 32'h0000_0000;
   localparam logic [1:0]  IRQEN_RESET = 2'h0;

   // ==========================================================
   // data structure in ram, and the ram window the dma may reach
   localparam logic [31:0] KEY_OFS     = 32'h0000_0000;
   localparam logic [31:0] CLEAR_OFS   = 32'h0000_0010;
   localparam logic [31:0] CIPHER_OFS  = 32'h0000_0020;
   localparam logic [32:0] STRUCT_LEN  = 33'h0_0000_0030;
   localparam logic [32:0] RAM_BASE    = 33'h0_2000_0000;
   localparam logic [32:0] RAM_SIZE    = 33'h0_0000_6000;

   // ==========================================================
   // word counts and aes constants
   localparam logic [3:0]  LAST_FETCH  = 4'h7;
   localparam logic [3:0]  FIRST_STORE = 4'h8;
   localparam logic [3:0]  LAST_STORE  = 4'hb;
   localparam logic [3:0]  LAST_ROUND  = 4'ha;
   localparam logic [7:0]  RCON_FIRST  = 8'h01;
   localparam logic [7:0]  AFFINE_C    = 8'h63;
   localparam logic [7:0]  GF_POLY     = 8'h1b;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_FETCH = 4'b0010,
      ST_CRYPT = 4'b0100,
      ST_STORE = 4'b1000
   } aesd_state_type;

   // dma master request and answer
   typedef struct packed {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } aesd_mem_req_type;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
   } aesd_mem_rsp_type;

endpackage : aesd_pkg
